// ---- cpw_defines.svh ----
// register map, field positions, reset values and timing counts
`ifndef CPW_DEFINES_SVH
`define CPW_DEFINES_SVH
`define CPW_ADDR_W 5
`define CPW_A_CTRL 5'h00
`define CPW_A_MODE 5'h01
`define CPW_A_CYC 5'h02
`define CPW_A_CNTL 5'h03
`define CPW_A_CNTH 5'h04
`define CPW_A_MMODE0 5'h05
`define CPW_A_CMPL0 5'h10
// control: counter overflow flag, run bit, module event flags at 0..n-1
`define CPW_CTRL_CF 7
`define CPW_CTRL_CR 6
// array mode
`define CPW_MD_IDL 7
`define CPW_MD_WATCHDOG_ENABLE 6
`define CPW_MD_WLCK 5
`define CPW_MD_CPS_HI 3
`define CPW_MD_CPS_LO 1
`define CPW_MD_RESET 8'h40
// shared cycle config
`define CPW_CY_RELOAD_BANK_SELECT 7
`define CPW_CY_CYCLE_OVERFLOW_FLAG 5
`define CPW_CY_CYCLE_LENGTH_SELECT_HI 1
`define CPW_CY_CYCLE_LENGTH_SELECT_LO 0
// module mode register
`define CPW_MM_WIDE 7
`define CPW_MM_ECOM 6
`define CPW_MM_MAT 3
`define CPW_MM_DUTY 1
`define CPW_MM_IRQEN 0
// counter-array clock dividers
`define CPW_DIV_SLOW 4'hB
`define CPW_DIV_MID 4'h3
`define CPW_DIV_FAST 4'h0
`define CPW_WDT_MODULE 2
`endif

// ---- cpw_pkg.sv ----
// types shared by the counter-array pwm and watchdog block
package cpw_pkg;
    typedef enum logic [1:0] {CPW_OFF, CPW_PWM8, CPW_DUTY_MODE_SELECT, CPW_PWM16} cpw_kind_t;
    typedef logic [7:0] cpw_byte_t;
endpackage : cpw_pkg

// ---- cpw_top.sv ----
// counter array with 8/9/10/11/16-bit pwm modules and module-2 watchdog
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "cpw_defines.svh"

module cpw_top #(
    parameter int NUM_MOD = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [`CPW_ADDR_W-1:0] regAddr,
    input wire cpw_pkg::cpw_byte_t regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output cpw_pkg::cpw_byte_t regRdData,
    // system side
    input wire logic cpuIdle,
    output logic wdtReset,
    // module output pins
    output logic [NUM_MOD-1:0] moduleOutputPin
);
    import cpw_pkg::*;

    localparam cpw_byte_t modeRst = `CPW_MD_RESET;

    // module 2 is the watchdog; event flags share the control byte
    if (NUM_MOD < 3 || NUM_MOD > 5) begin : g_badNumMod
        $error("NUM_MOD must lie in 3..5");
    end

    // =========================================================
    // decode helpers
    // =========================================================
    function automatic cpw_kind_t kindOf(input cpw_byte_t mode, input logic [1:0] cycle_length_select);
        if (!mode[`CPW_MM_DUTY]) begin
            kindOf = CPW_OFF;
        end else if (mode[`CPW_MM_WIDE]) begin
            kindOf = CPW_PWM16;
        end else if (cycle_length_select == 2'b00) begin
            kindOf = CPW_PWM8;
        end else begin
            kindOf = CPW_DUTY_MODE_SELECT;
        end
    endfunction : kindOf

    function automatic logic [3:0] divOf(input logic [2:0] cps);
        unique case (cps)
            3'h0: divOf = `CPW_DIV_SLOW;
            3'h1: divOf = `CPW_DIV_MID;
            default: divOf = `CPW_DIV_FAST;
        endcase
    endfunction : divOf

    function automatic logic [15:0] maskOf(input logic [1:0] cycle_length_select);
        unique case (cycle_length_select)
            2'b01: maskOf = 16'h01FF;
            2'b10: maskOf = 16'h03FF;
            2'b11: maskOf = 16'h07FF;
            default: maskOf = 16'h00FF;
        endcase
    endfunction : maskOf

    // =========================================================
    // state
    // =========================================================
    logic idleMeta_q, idleSync_q;
    logic [3:0] presc_q, presc_d;
    logic [15:0] cnt_q, cnt_d;
    logic cf_q, cf_d, cr_q, cr_d, cycle_overflow_flag_q, cycle_overflow_flag_d;
    logic idl_q, idl_d, watchdog_enable_q, watchdog_enable_d, wlck_q, wlck_d;
    logic [2:0] cps_q, cps_d;
    logic reload_bank_select_q, reload_bank_select_d;
    logic [1:0] cycle_length_select_q, cycle_length_select_d;
    logic [NUM_MOD-1:0] ccf_q, ccf_d, out_q, out_d;
    cpw_byte_t mode_q [NUM_MOD];
    cpw_byte_t mode_d [NUM_MOD];
    cpw_byte_t cmpL_q [NUM_MOD];
    cpw_byte_t cmpL_d [NUM_MOD];
    cpw_byte_t cmpH_q [NUM_MOD];
    cpw_byte_t cmpH_d [NUM_MOD];
    cpw_byte_t arL_q [NUM_MOD];
    cpw_byte_t arL_d [NUM_MOD];
    cpw_byte_t arH_q [NUM_MOD];
    cpw_byte_t arH_d [NUM_MOD];
    logic wdtRst_d, wdtRst_q;
    cpw_byte_t rd_d, rd_q;

    logic wdtOn, run, tick, ovfLow, ovfN, ovf16;
    logic [15:0] cntNext, nMask;
    assign wdtOn = watchdog_enable_q | wlck_q;
    // idle only suspends when asked to
    assign run = (cr_q | wdtOn) & ~(idl_q & idleSync_q);
    assign tick = run & (presc_q == divOf(cps_q));
    assign cntNext = cnt_q + 16'h0001;
    assign nMask = maskOf(cycle_length_select_q);
    assign ovfLow = tick & (cnt_q[7:0] == 8'hFF);
    assign ovfN = tick & ((cnt_q & nMask) == nMask);
    assign ovf16 = tick & (cnt_q == 16'hFFFF);

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic [15:0] cmpUse;
        logic wMode, wCmpL, wCmpH, hit, isWdt;
        cpw_kind_t k;
        cmpUse = 16'h0000;
        wMode = 1'b0;
        wCmpL = 1'b0;
        wCmpH = 1'b0;
        hit = 1'b0;
        isWdt = 1'b0;
        k = CPW_OFF;
        presc_d = tick || !run ? 4'h0 : presc_q + 4'h1;
        cnt_d = tick ? cntNext : cnt_q;
        cf_d = cf_q;
        cr_d = cr_q;
        cycle_overflow_flag_d = cycle_overflow_flag_q;
        idl_d = idl_q;
        watchdog_enable_d = watchdog_enable_q;
        wlck_d = wlck_q;
        cps_d = cps_q;
        reload_bank_select_d = reload_bank_select_q;
        cycle_length_select_d = cycle_length_select_q;
        ccf_d = ccf_q;
        out_d = out_q;
        wdtRst_d = 1'b0;
        // software writes first, so hardware sets below win
        if (regWrStb) begin
            unique case (regAddr)
                `CPW_A_CTRL: begin
                    cf_d = regWrData[`CPW_CTRL_CF];
                    cr_d = regWrData[`CPW_CTRL_CR];
                    ccf_d = regWrData[NUM_MOD-1:0];
                    if (wdtOn && regWrData[`CPW_WDT_MODULE]) begin
                        wdtRst_d = 1'b1;
                    end
                end
                `CPW_A_MODE: begin
                    if (!wdtOn) begin
                        idl_d = regWrData[`CPW_MD_IDL];
                        cps_d = regWrData[`CPW_MD_CPS_HI:`CPW_MD_CPS_LO];
                    end
                    watchdog_enable_d = regWrData[`CPW_MD_WATCHDOG_ENABLE];
                    wlck_d = wlck_q | regWrData[`CPW_MD_WLCK];
                end
                `CPW_A_CYC: begin
                    reload_bank_select_d = regWrData[`CPW_CY_RELOAD_BANK_SELECT];
                    cycle_overflow_flag_d = regWrData[`CPW_CY_CYCLE_OVERFLOW_FLAG];
                    cycle_length_select_d = regWrData[`CPW_CY_CYCLE_LENGTH_SELECT_HI:`CPW_CY_CYCLE_LENGTH_SELECT_LO];
                end
                `CPW_A_CNTL: begin
                    if (!wdtOn) begin
                        cnt_d[7:0] = regWrData;
                    end
                end
                `CPW_A_CNTH: begin
                    if (!wdtOn) begin
                        cnt_d[15:8] = regWrData;
                    end
                end
                default: begin
                end
            endcase
        end
        if (ovf16) begin
            cf_d = 1'b1;
        end
        if (ovfN) begin
            cycle_overflow_flag_d = 1'b1;
        end
        // watchdog expiry on low-byte overflow while update byte matches
        if (wdtOn && ovfLow && cmpH_q[`CPW_WDT_MODULE] == cnt_q[15:8]) begin
            wdtRst_d = 1'b1;
        end
        for (int n = 0; n < NUM_MOD; n++) begin
            isWdt = wdtOn && n == `CPW_WDT_MODULE;
            wMode = regWrStb && regAddr == `CPW_A_MMODE0 + 5'(n);
            wCmpL = regWrStb && regAddr == `CPW_A_CMPL0 + 5'(2 * n);
            wCmpH = regWrStb && regAddr == `CPW_A_CMPL0 + 5'(2 * n + 1);
            mode_d[n] = mode_q[n];
            cmpL_d[n] = cmpL_q[n];
            cmpH_d[n] = cmpH_q[n];
            arL_d[n] = arL_q[n];
            arH_d[n] = arH_q[n];
            if (wMode && !isWdt) begin
                mode_d[n] = regWrData;
            end
            // mode register locked under watchdog, so no enable side effect
            if (wCmpL && !isWdt) begin
                mode_d[n][`CPW_MM_ECOM] = 1'b0;
            end
            if (wCmpH && !isWdt) begin
                mode_d[n][`CPW_MM_ECOM] = 1'b1;
            end
            if (wCmpL) begin
                if (reload_bank_select_q) begin
                    arL_d[n] = regWrData;
                end else begin
                    cmpL_d[n] = regWrData;
                end
            end
            if (wCmpH) begin
                if (isWdt) begin
                    cmpH_d[n] = 8'(cnt_q[15:8] + cmpL_q[n]);
                end else if (reload_bank_select_q) begin
                    arH_d[n] = regWrData;
                end else begin
                    cmpH_d[n] = regWrData;
                end
            end
            // watchdog module behaves as a software timer: no pwm, pin low
            k = isWdt ? CPW_OFF : kindOf(mode_q[n], cycle_length_select_q);
            hit = 1'b0;
            unique case (k)
                CPW_PWM8: begin
                    cmpUse = {8'h00, ovfLow ? cmpH_d[n] : cmpL_d[n]};
                    if (ovfLow) begin
                        cmpL_d[n] = cmpH_d[n];
                        out_d[n] = 1'b0;
                    end
                    // reloaded value compared right away: high byte 0 gives 100%
                    hit = tick && cntNext[7:0] == cmpUse[7:0];
                end
                CPW_DUTY_MODE_SELECT: begin
                    cmpUse = ovfN ? {arH_d[n], arL_d[n]} : {cmpH_d[n], cmpL_d[n]};
                    if (ovfN) begin
                        {cmpH_d[n], cmpL_d[n]} = cmpUse;
                        out_d[n] = 1'b0;
                    end
                    hit = tick && (cntNext & nMask) == (cmpUse & nMask);
                end
                CPW_PWM16: begin
                    cmpUse = {cmpH_d[n], cmpL_d[n]};
                    if (ovf16) begin
                        out_d[n] = 1'b0;
                    end
                    hit = tick && cntNext == cmpUse;
                end
                default: begin
                    out_d[n] = 1'b0;
                end
            endcase
            if (hit) begin
                out_d[n] = 1'b1;
                if (mode_q[n][`CPW_MM_MAT]) begin
                    ccf_d[n] = 1'b1;
                end
            end
            if (!mode_d[n][`CPW_MM_ECOM]) begin
                out_d[n] = 1'b0;
            end
        end
    end

    // =========================================================
    // read path
    // =========================================================
    always_comb begin
        rd_d = 8'h00;
        if (regRdStb) begin
            unique case (regAddr)
                `CPW_A_CTRL: begin
                    rd_d[`CPW_CTRL_CF] = cf_q;
                    rd_d[`CPW_CTRL_CR] = cr_q;
                    rd_d[NUM_MOD-1:0] = ccf_q;
                end
                `CPW_A_MODE: begin
                    rd_d[`CPW_MD_IDL] = idl_q;
                    rd_d[`CPW_MD_WATCHDOG_ENABLE] = watchdog_enable_q;
                    rd_d[`CPW_MD_WLCK] = wlck_q;
                    rd_d[`CPW_MD_CPS_HI:`CPW_MD_CPS_LO] = cps_q;
                end
                `CPW_A_CYC: begin
                    rd_d[`CPW_CY_RELOAD_BANK_SELECT] = reload_bank_select_q;
                    rd_d[`CPW_CY_CYCLE_OVERFLOW_FLAG] = cycle_overflow_flag_q;
                    rd_d[`CPW_CY_CYCLE_LENGTH_SELECT_HI:`CPW_CY_CYCLE_LENGTH_SELECT_LO] = cycle_length_select_q;
                end
                `CPW_A_CNTL: rd_d = cnt_q[7:0];
                `CPW_A_CNTH: rd_d = cnt_q[15:8];
                default: begin
                    for (int n = 0; n < NUM_MOD; n++) begin
                        if (regAddr == `CPW_A_MMODE0 + 5'(n)) begin
                            rd_d = mode_q[n];
                        end
                        if (regAddr == `CPW_A_CMPL0 + 5'(2 * n)) begin
                            rd_d = reload_bank_select_q ? arL_q[n] : cmpL_q[n];
                        end
                        if (regAddr == `CPW_A_CMPL0 + 5'(2 * n + 1)) begin
                            rd_d = reload_bank_select_q ? arH_q[n] : cmpH_q[n];
                        end
                    end
                end
            endcase
        end
    end

    // =========================================================
    // registers
    // =========================================================
    always_ff @(posedge core_clk) begin
        // idle pin is foreign to this clock
        idleMeta_q <= cpuIdle;
        idleSync_q <= idleMeta_q;
        if (!nrst) begin
            presc_q <= 4'h0;
            cnt_q <= 16'h0000;
            cf_q <= 1'b0;
            cr_q <= 1'b0;
            cycle_overflow_flag_q <= 1'b0;
            idl_q <= modeRst[`CPW_MD_IDL];
            watchdog_enable_q <= modeRst[`CPW_MD_WATCHDOG_ENABLE];
            wlck_q <= modeRst[`CPW_MD_WLCK];
            cps_q <= 3'h0;
            reload_bank_select_q <= 1'b0;
            cycle_length_select_q <= 2'b00;
            ccf_q <= '0;
            out_q <= '0;
            wdtRst_q <= 1'b0;
            rd_q <= 8'h00;
            for (int n = 0; n < NUM_MOD; n++) begin
                mode_q[n] <= 8'h00;
                cmpL_q[n] <= 8'h00;
                cmpH_q[n] <= 8'h00;
                arL_q[n] <= 8'h00;
                arH_q[n] <= 8'h00;
            end
        end else begin
            presc_q <= presc_d;
            cnt_q <= cnt_d;
            cf_q <= cf_d;
            cr_q <= cr_d;
            cycle_overflow_flag_q <= cycle_overflow_flag_d;
            idl_q <= idl_d;
            watchdog_enable_q <= watchdog_enable_d;
            wlck_q <= wlck_d;
            cps_q <= cps_d;
            reload_bank_select_q <= reload_bank_select_d;
            cycle_length_select_q <= cycle_length_select_d;
            ccf_q <= ccf_d;
            out_q <= out_d;
            wdtRst_q <= wdtRst_d;
            rd_q <= rd_d;
            for (int n = 0; n < NUM_MOD; n++) begin
                mode_q[n] <= mode_d[n];
                cmpL_q[n] <= cmpL_d[n];
                cmpH_q[n] <= cmpH_d[n];
                arL_q[n] <= arL_d[n];
                arH_q[n] <= arH_d[n];
            end
        end
    end

    assign regRdData = rd_q;
    assign wdtReset = wdtRst_q;
    assign moduleOutputPin = out_q;
endmodule : cpw_top
`default_nettype wire

// ---- cpw_top_sva.sv ----
// concurrent checks on the ports of the counter-array pwm and watchdog block
`timescale 1ns/10ps
`default_nettype none
`include "cpw_defines.svh"
module cpw_top_sva #(
    parameter int NUM_MOD = 3
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [`CPW_ADDR_W-1:0] regAddr,
    input wire cpw_pkg::cpw_byte_t regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire cpw_pkg::cpw_byte_t regRdData,
    // system side and pins
    input wire logic cpuIdle,
    input wire logic wdtReset,
    input wire logic [NUM_MOD-1:0] moduleOutputPin
);
    import cpw_pkg::*;
    // ==========
    // shadow state
    logic wdtOn_q, wdtOn_d, lock_q, lock_d, bank_q, bank_d, ecom_q, ecom_d;
    logic quiet_q, quiet_d, seen_q, seen_d;
    logic [15:0] cyc_q, cyc_d;
    always_comb begin
        wdtOn_d = wdtOn_q;
        lock_d = lock_q;
        bank_d = bank_q;
        ecom_d = ecom_q;
        if (regWrStb && regAddr == `CPW_A_MODE) begin
            lock_d = lock_q | regWrData[`CPW_MD_WLCK];
            wdtOn_d = lock_d | regWrData[`CPW_MD_WATCHDOG_ENABLE];
        end
        if (regWrStb && regAddr == `CPW_A_CYC) bank_d = regWrData[`CPW_CY_RELOAD_BANK_SELECT];
        if (regWrStb && regAddr == `CPW_A_MMODE0) ecom_d = regWrData[`CPW_MM_ECOM];
        // reload-bank writes left out: their effect on the enable is open
        if (regWrStb && !bank_q && regAddr == `CPW_A_CMPL0) ecom_d = 1'b0;
        if (regWrStb && !bank_q && regAddr == `CPW_A_CMPL0 + 5'h01) ecom_d = 1'b1;
        quiet_d = quiet_q & ~regWrStb;
        cyc_d = cyc_q + 16'h0001;
        seen_d = seen_q | (quiet_q & wdtReset);
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wdtOn_q <= 1'b1;
            lock_q <= 1'b0;
            bank_q <= 1'b0;
            ecom_q <= 1'b0;
            quiet_q <= 1'b1;
            seen_q <= 1'b0;
            cyc_q <= 16'h0000;
        end else begin
            wdtOn_q <= wdtOn_d;
            lock_q <= lock_d;
            bank_q <= bank_d;
            ecom_q <= ecom_d;
            quiet_q <= quiet_d;
            seen_q <= seen_d;
            cyc_q <= cyc_d;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_rd_idle; !regRdStb |=> regRdData == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; regRdStb && regAddr == 5'h1F |=> regRdData == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_wdt_pulse; wdtReset |=> !wdtReset; endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("reset pulse too long");
    property p_force;
        regWrStb && regAddr == `CPW_A_CTRL && regWrData[2] && wdtOn_q |=> wdtReset;
    endproperty
    a_force: assert property (p_force) else $error("flag write gave no reset");
    property p_wdt_off; !wdtOn_q && !$past(wdtOn_q) |-> !wdtReset; endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("reset while disabled");
    property p_tmo_early;
        quiet_q && wdtReset |-> cyc_q >= 16'h0BF4 && cyc_q <= 16'h0C12;
    endproperty
    a_tmo_early: assert property (p_tmo_early) else $error("default timeout off");
    property p_tmo_seen; quiet_q && cyc_q == 16'h0C1C |-> seen_q; endproperty
    a_tmo_seen: assert property (p_tmo_seen) else $error("no default timeout");
    property p_off_pin; !ecom_q && !$past(ecom_q) |-> !moduleOutputPin[0]; endproperty
    a_off_pin: assert property (p_off_pin) else $error("pin high while disabled");
    c_wdt: cover property (wdtReset);
    c_pin: cover property ($rose(moduleOutputPin[0]));
    c_rd: cover property (regRdStb ##1 regRdData != 8'h00);
    c_idle: cover property (cpuIdle ##4 regRdStb);
endmodule : cpw_top_sva
bind cpw_top cpw_top_sva #(.NUM_MOD(NUM_MOD)) u_sva (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .cpuIdle(cpuIdle), .wdtReset(wdtReset), .moduleOutputPin(moduleOutputPin)
);
`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench for the counter-array pwm and watchdog block
`timescale 1ns/10ps
`default_nettype none
`include "cpw_defines.svh"
module tb_top;
    import cpw_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [`CPW_ADDR_W-1:0] regAddr = 5'h00;
    cpw_byte_t regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic cpuIdle = 1'b0;
    cpw_byte_t regRdData, last, h;
    logic wdtReset;
    logic [2:0] pin;
    int err_count = 0;
    int n_compared = 0;
    int seed = 5;
    int cnt, v, per;
    cpw_top #(.NUM_MOD(3)) dut (
        .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .cpuIdle(cpuIdle), .wdtReset(wdtReset), .moduleOutputPin(pin)
    );
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    // ==========
    // bus and measurement tasks
    task automatic test_done();
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // every signal assigned once per edge, so strobes can run back to back
    task automatic step(input logic w, input logic r, input logic [4:0] a, input cpw_byte_t d);
        regWrStb <= w;
        regRdStb <= r;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        last = regRdData;
    endtask : step
    task automatic wr(input logic [4:0] a, input cpw_byte_t d);
        step(1'b1, 1'b0, a, d);
    endtask : wr
    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b0, 5'h00, 8'h00);
    endtask : idle
    task automatic rdchk(input string what, input logic [4:0] a, input cpw_byte_t e);
        step(1'b0, 1'b1, a, 8'h00);
        idle(1);
        check(what, 16'(last), 16'(e));
    endtask : rdchk
    task automatic hi(input int n);
        cnt = 0;
        repeat (n) begin
            idle(1);
            cnt += (pin[0] === 1'b1) ? 1 : 0;
        end
    endtask : hi
    task automatic wwait(input int n);
        cnt = 0;
        while (cnt < n && wdtReset !== 1'b1) begin
            idle(1);
            cnt++;
        end
    endtask : wwait
    task automatic do_reset();
        nrst <= 1'b0;
        idle(5);
        nrst <= 1'b1;
        idle(1);
    endtask : do_reset
    // ==========
    // scenarios
    initial begin
        do_reset();
        rdchk("mode", `CPW_A_MODE, `CPW_MD_RESET);
        rdchk("control", `CPW_A_CTRL, 8'h00);
        rdchk("unmapped", 5'h1F, 8'h00);
        wwait(3200);
        check("first timeout", 16'(cnt >= 3050 && cnt <= 3080), 16'h0001);
        // stay quiet so the checker can confirm the default expiry
        idle(30);
        wr(`CPW_A_CNTH, 8'h55);
        rdchk("locked count", `CPW_A_CNTH, 8'h01);
        wr(`CPW_A_MODE, 8'hC6);
        rdchk("frozen mode", `CPW_A_MODE, 8'h40);
        wr(`CPW_A_CTRL, 8'h04);
        wwait(3);
        check("forced reset", 16'(wdtReset), 16'h0001);
        wr(`CPW_A_MODE, 8'h20);
        wr(`CPW_A_MODE, 8'h00);
        wr(`CPW_A_CTRL, 8'h04);
        wwait(3);
        check("locked watchdog", 16'(wdtReset), 16'h0001);
        do_reset();
        wr(`CPW_A_MODE, 8'h00);
        wr(`CPW_A_MODE, 8'h04);
        wr(`CPW_A_CTRL, 8'h04);
        wwait(3);
        check("watchdog off", 16'(wdtReset), 16'h0000);
        wr(`CPW_A_CTRL, 8'h40);
        for (int i = 0; i < 5; i++) begin
            h = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            wr(`CPW_A_CYC, 8'h00);
            wr(`CPW_A_MMODE0, 8'h4A);
            // low byte zeroed on purpose: only the wrap reload fixes the duty
            wr(`CPW_A_CMPL0, 8'h00);
            rdchk("enable cleared", `CPW_A_MMODE0, 8'h0A);
            wr(`CPW_A_CMPL0 + 5'h01, h);
            idle(300);
            hi(256);
            check("8-bit high", 16'(cnt), 16'(256 - h));
        end
        rdchk("cycle flag", `CPW_A_CYC, 8'h20);
        rdchk("match flag", `CPW_A_CTRL, 8'h41);
        wr(`CPW_A_CMPL0, 8'h00);
        idle(4);
        hi(256);
        check("disabled high", 16'(cnt), 16'h0000);
        check("other pins", 16'(pin[2:1]), 16'h0000);
        for (int n = 1; n < 4; n++) begin
            per = 1 << (8 + n);
            v = $random(seed) & (per - 1);
            wr(`CPW_A_MMODE0, 8'h4A);
            wr(`CPW_A_CYC, 8'h80 | 8'(n));
            wr(`CPW_A_CMPL0, 8'(v));
            wr(`CPW_A_CMPL0 + 5'h01, 8'(v >> 8));
            rdchk("reload low", `CPW_A_CMPL0, 8'(v));
            wr(`CPW_A_CYC, 8'(n));
            wr(`CPW_A_CMPL0, 8'h00);
            wr(`CPW_A_CMPL0 + 5'h01, 8'h00);
            idle(per + 8);
            hi(per);
            check("n-bit high", 16'(cnt), 16'(per - v));
            rdchk("overflow flag", `CPW_A_CYC, 8'h20 | 8'(n));
        end
        wr(`CPW_A_CTRL, 8'h00);
        wr(`CPW_A_MMODE0, 8'hCB);
        wr(`CPW_A_CMPL0, 8'hF0);
        wr(`CPW_A_CNTL, 8'hE0);
        wr(`CPW_A_CNTH, 8'hFF);
        wr(`CPW_A_CMPL0 + 5'h01, 8'hFF);
        wr(`CPW_A_CTRL, 8'h40);
        hi(64);
        check("16-bit high", 16'(cnt), 16'h0010);
        rdchk("wrap flags", `CPW_A_CTRL, 8'hC1);
        // next duty written while the counter is stopped
        wr(`CPW_A_CTRL, 8'h00);
        wr(`CPW_A_CMPL0, 8'hF8);
        wr(`CPW_A_CNTL, 8'hE0);
        wr(`CPW_A_CNTH, 8'hFF);
        wr(`CPW_A_CMPL0 + 5'h01, 8'hFF);
        wr(`CPW_A_CTRL, 8'h40);
        hi(64);
        check("16-bit update", 16'(cnt), 16'h0008);
        // idle suspend: counter must hold while the idle pin is high
        wr(`CPW_A_MODE, 8'h84);
        cpuIdle <= 1'b1;
        idle(4);
        step(1'b0, 1'b1, `CPW_A_CNTL, 8'h00);
        idle(1);
        h = last;
        idle(20);
        rdchk("idle suspend", `CPW_A_CNTL, h);
        cpuIdle <= 1'b0;
        do_reset();
        wr(`CPW_A_MODE, 8'h00);
        wr(`CPW_A_MODE, 8'h04);
        wr(`CPW_A_CMPL0 + 5'h04, 8'h02);
        wr(`CPW_A_MODE, 8'h44);
        wr(`CPW_A_CMPL0 + 5'h05, 8'h00);
        wwait(1000);
        check("update timeout", 16'(cnt >= 740 && cnt <= 780), 16'h0001);
        test_done();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
